// File: rtl/tcc_timer.sv
// Free-running 16-bit timer with four capture and two compare channels,
// status and control registers, reached over an AHB-Lite slave port.
// Assumes one MCLK domain; capture pins and external clock are async.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module tcc_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             MCLK,
  input  wire logic             RESET,
  // AHB-Lite slave
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic             HREADY,
  input  wire logic [31:0]      HWDATA,
  output logic      [31:0]      HRDATA,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  // Capture and clock pins
  input  wire logic             CAP_PIN_A,
  input  wire logic             CAP_PIN_B,
  input  wire logic             CAP_PIN_C,
  input  wire logic             CAP_PIN_D,
  input  wire logic             EXT_CLK_PIN,
  // Chip power mode, from logic on MCLK
  input  wire logic             LOW_POWER,
  // Interrupt request
  output logic                  IRQ
);

  logic             hold_clr;
  logic [7:1]       flags_q;
  logic [7:1]       armed_q;
  logic             clr_match_q;
  logic [7:0]       ctrl_q;
  logic [7:1]       irq_en_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] cmp_a_q;
  logic [CNT_W-1:0] cmp_b_q;
  logic [CNT_W-1:0] cap_a_q;
  logic [CNT_W-1:0] cap_b_q;
  logic [CNT_W-1:0] cap_c_q;
  logic [CNT_W-1:0] cap_d_q;
  logic [4:0]       presc_q;
  logic             pend_q;
  logic             pend_wr_q;
  logic [7:0]       pend_addr_q;
  logic [4:0]       pin_rise;
  logic [4:0]       pin_fall;
  logic             tick;
  logic             match_a;
  logic             match_b;
  logic             wrap;
  logic             evt_a;
  logic             evt_b;
  logic             evt_c;
  logic             evt_d;
  logic [7:1]       set_vec;
  logic [7:1]       clr_vec;
  logic             wr_data;
  logic             rd_data;

  // ==========================================================================
  // Helpers
  function automatic logic edge_hit(input logic r, input logic f, input logic sel);
    edge_hit = sel ? r : f;
  endfunction

  function automatic logic wr_at(input logic [7:0] ofs, input logic en,
                                 input logic [7:0] a);
    wr_at = en && (a == ofs);
  endfunction

  assign hold_clr = RESET || LOW_POWER;

  // ==========================================================================
  // Pin synchronisers
  tcc_pin_sync #(
    .W (5)
  ) u_sync (
    .clk  (MCLK),
    .rst  (RESET),
    .pin  ({EXT_CLK_PIN, CAP_PIN_D, CAP_PIN_C, CAP_PIN_B, CAP_PIN_A}),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  // ==========================================================================
  // Bus slave: every transfer takes one wait state, so a write is in place
  // before any later read looks at the registers
  assign wr_data = pend_q && pend_wr_q && !HREADYOUT;
  assign rd_data = pend_q && !pend_wr_q && !HREADYOUT;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pend_q      <= 1'b0;
      pend_wr_q   <= 1'b0;
      pend_addr_q <= 8'h00;
      HREADYOUT   <= 1'b1;
      HRESP       <= 1'b0;
    end else if (HSEL && HTRANS[1] && HREADY) begin
      pend_q      <= 1'b1;
      pend_wr_q   <= HWRITE;
      pend_addr_q <= {HADDR[7:2], 2'b00};
      HREADYOUT   <= 1'b0;
    end else begin
      pend_q      <= 1'b0;
      HREADYOUT   <= 1'b1;
    end
  end

  // Unmapped offsets read zero
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      HRDATA <= 32'h0000_0000;
    end else if (rd_data) begin
      unique case (pend_addr_q)
        tcc_pkg::OFS_STATUS:  HRDATA <= {24'h0, flags_q, clr_match_q};
        tcc_pkg::OFS_CONTROL: HRDATA <= {24'h0, ctrl_q};
        tcc_pkg::OFS_IRQ_EN:  HRDATA <= {24'h0, irq_en_q, 1'b1};
        tcc_pkg::OFS_COUNT:   HRDATA <= 32'(count_q);
        tcc_pkg::OFS_CMP_A:   HRDATA <= 32'(cmp_a_q);
        tcc_pkg::OFS_CMP_B:   HRDATA <= 32'(cmp_b_q);
        tcc_pkg::OFS_CAP_A:   HRDATA <= 32'(cap_a_q);
        tcc_pkg::OFS_CAP_B:   HRDATA <= 32'(cap_b_q);
        tcc_pkg::OFS_CAP_C:   HRDATA <= 32'(cap_c_q);
        tcc_pkg::OFS_CAP_D:   HRDATA <= 32'(cap_d_q);
        default:              HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Control, interrupt enable and compare registers
  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      ctrl_q <= tcc_pkg::CONTROL_RST;
    end else if (wr_at(tcc_pkg::OFS_CONTROL, wr_data, pend_addr_q)) begin
      ctrl_q <= HWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      irq_en_q <= tcc_pkg::IRQ_EN_RST[7:1];
    end else if (wr_at(tcc_pkg::OFS_IRQ_EN, wr_data, pend_addr_q)) begin
      irq_en_q <= HWDATA[7:1];
    end
  end

  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      cmp_a_q <= CNT_W'(tcc_pkg::CMP_RST);
      cmp_b_q <= CNT_W'(tcc_pkg::CMP_RST);
    end else begin
      if (wr_at(tcc_pkg::OFS_CMP_A, wr_data, pend_addr_q)) begin
        cmp_a_q <= HWDATA[CNT_W-1:0];
      end
      if (wr_at(tcc_pkg::OFS_CMP_B, wr_data, pend_addr_q)) begin
        cmp_b_q <= HWDATA[CNT_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Prescaler and counter
  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      presc_q <= 5'h00;
    end else begin
      presc_q <= presc_q + 5'h01;
    end
  end

  always_comb begin
    unique case (ctrl_q[tcc_pkg::BIT_CLK_SEL_HI:tcc_pkg::BIT_CLK_SEL_LO])
      tcc_pkg::CLK_DIV2:  tick = (presc_q[0] == tcc_pkg::DIV2_LAST[0]);
      tcc_pkg::CLK_DIV8:  tick = (presc_q[2:0] == tcc_pkg::DIV8_LAST[2:0]);
      tcc_pkg::CLK_DIV32: tick = (presc_q == tcc_pkg::DIV32_LAST);
      tcc_pkg::CLK_EXT:   tick = pin_rise[4];
    endcase
  end

  assign match_a = tick && (count_q == cmp_a_q);
  assign match_b = tick && (count_q == cmp_b_q);
  // A clear by match A at the top count is not a wrap
  assign wrap    = tick && (&count_q) && !(match_a && clr_match_q);

  // A software write to the counter wins over a tick in the same cycle
  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      count_q <= CNT_W'(tcc_pkg::COUNT_RST);
    end else if (wr_at(tcc_pkg::OFS_COUNT, wr_data, pend_addr_q)) begin
      count_q <= HWDATA[CNT_W-1:0];
    end else if (match_a && clr_match_q) begin
      count_q <= '0;
    end else if (tick) begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  // ==========================================================================
  // Capture events
  always_comb begin
    evt_a = edge_hit(pin_rise[0], pin_fall[0], ctrl_q[tcc_pkg::BIT_EDGE_SEL_A])
          || (ctrl_q[tcc_pkg::BIT_BUFFER_EN_A]
              && edge_hit(pin_rise[0], pin_fall[0], ctrl_q[tcc_pkg::BIT_EDGE_SEL_C]));
    evt_b = edge_hit(pin_rise[1], pin_fall[1], ctrl_q[tcc_pkg::BIT_EDGE_SEL_B]);
    evt_c = edge_hit(pin_rise[2], pin_fall[2], ctrl_q[tcc_pkg::BIT_EDGE_SEL_C]);
    evt_d = edge_hit(pin_rise[3], pin_fall[3], ctrl_q[tcc_pkg::BIT_EDGE_SEL_D]);
  end

  // Captures load regardless of the state of their flags
  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      cap_a_q <= CNT_W'(tcc_pkg::CAP_RST);
      cap_c_q <= CNT_W'(tcc_pkg::CAP_RST);
    end else begin
      if (evt_a) begin
        cap_a_q <= count_q;
      end
      if (ctrl_q[tcc_pkg::BIT_BUFFER_EN_A]) begin
        if (evt_a) begin
          cap_c_q <= cap_a_q;
        end
      end else if (evt_c) begin
        cap_c_q <= count_q;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      cap_b_q <= CNT_W'(tcc_pkg::CAP_RST);
      cap_d_q <= CNT_W'(tcc_pkg::CAP_RST);
    end else begin
      if (evt_b) begin
        cap_b_q <= count_q;
      end
      if (ctrl_q[tcc_pkg::BIT_BUFFER_EN_B]) begin
        if (evt_b) begin
          cap_d_q <= cap_b_q;
        end
      end else if (evt_d) begin
        cap_d_q <= count_q;
      end
    end
  end

  // ==========================================================================
  // Status flags
  // Channel C and D flags follow their own pins even in buffer mode, so
  // they serve as plain external interrupts there
  assign set_vec = {evt_a, evt_b, evt_c, evt_d, match_a, match_b, wrap};

  // Only bits read as one since their last clear may be cleared
  assign clr_vec = wr_at(tcc_pkg::OFS_STATUS, wr_data, pend_addr_q)
                 ? (~HWDATA[7:1] & armed_q) : 7'h00;

  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      flags_q <= tcc_pkg::STATUS_RST[7:1];
    end else begin
      flags_q <= (flags_q & ~clr_vec) | set_vec;
    end
  end

  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      armed_q <= 7'h00;
    end else if (rd_data && (pend_addr_q == tcc_pkg::OFS_STATUS)) begin
      armed_q <= armed_q | flags_q;
    end else begin
      armed_q <= armed_q & ~clr_vec;
    end
  end

  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      clr_match_q <= tcc_pkg::STATUS_RST[tcc_pkg::BIT_CLR_MATCH_A];
    end else if (wr_at(tcc_pkg::OFS_STATUS, wr_data, pend_addr_q)) begin
      clr_match_q <= HWDATA[tcc_pkg::BIT_CLR_MATCH_A];
    end
  end

  always_ff @(posedge MCLK) begin
    if (hold_clr) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(flags_q & irq_en_q);
    end
  end

  // ==========================================================================
  // Checks
  chk_flag_no_swset: assert property (@(posedge MCLK) disable iff (hold_clr)
    ##1 ((flags_q & ~$past(flags_q) & ~$past(set_vec)) == 7'h00))
    else $error("status flag rose without a hardware event");

  chk_clear_after_read: assert property (@(posedge MCLK) disable iff (hold_clr)
    ##1 ((~flags_q & $past(flags_q) & ~$past(armed_q)) == 7'h00))
    else $error("status flag cleared without a prior read");

  chk_status_lowpow: assert property (@(posedge MCLK) disable iff (RESET)
    LOW_POWER |=> (flags_q == 7'h00) && !clr_match_q)
    else $error("status not cleared in low power");

  chk_ctrl_lowpow: assert property (@(posedge MCLK) disable iff (RESET)
    LOW_POWER |=> (ctrl_q == 8'h00))
    else $error("control not cleared in low power");

  chk_capture_a: assert property (@(posedge MCLK) disable iff (hold_clr)
    evt_a |=> flags_q[7] && (cap_a_q == $past(count_q)))
    else $error("capture A did not load or flag");

  chk_buffer_shift: assert property (@(posedge MCLK) disable iff (hold_clr)
    (evt_a && ctrl_q[3]) |=> (cap_c_q == $past(cap_a_q)) && flags_q[7])
    else $error("buffered capture A did not shift into C");

  chk_flag_c_buf: assert property (@(posedge MCLK) disable iff (hold_clr)
    (evt_c && ctrl_q[3] && !evt_a) |=> flags_q[5] && $stable(cap_c_q))
    else $error("channel C flag or register wrong in buffer mode");

  chk_cmp_a_flag: assert property (@(posedge MCLK) disable iff (hold_clr)
    (tick && (count_q == cmp_a_q)) |=> flags_q[3])
    else $error("compare A match did not set flag");

  chk_wrap_flag: assert property (@(posedge MCLK) disable iff (hold_clr)
    (wrap && !wr_data) |=> flags_q[1] && (count_q == '0))
    else $error("wrap did not set flag or reach zero");

  chk_match_clear: assert property (@(posedge MCLK) disable iff (hold_clr)
    (match_a && clr_match_q && !wr_data) |=> (count_q == '0))
    else $error("match A did not clear the counter");

  chk_div2_rate: assert property (@(posedge MCLK) disable iff (hold_clr)
    (ctrl_q[1:0] == 2'h0 && !wr_data && tick) |=> !tick ##1 (tick || ctrl_q[1:0] != 2'h0))
    else $error("divide by two tick spacing wrong");

  chk_irq_raise: assert property (@(posedge MCLK) disable iff (hold_clr)
    (|(flags_q & irq_en_q)) |=> IRQ)
    else $error("enabled flag did not raise interrupt");

  chk_set_wins: assert property (@(posedge MCLK) disable iff (hold_clr)
    (|(set_vec & clr_vec)) |=> (|(flags_q & $past(set_vec & clr_vec))))
    else $error("clear beat a simultaneous set");

endmodule

// File: rtl/tcc_pkg.sv
// Package for the capture/compare timer: register map, field layout,
// reset values and prescaler counts.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package tcc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0c;
  localparam logic [7:0] OFS_CMP_A   = 8'h10;
  localparam logic [7:0] OFS_CMP_B   = 8'h14;
  localparam logic [7:0] OFS_CAP_A   = 8'h18;
  localparam logic [7:0] OFS_CAP_B   = 8'h1c;
  localparam logic [7:0] OFS_CAP_C   = 8'h20;
  localparam logic [7:0] OFS_CAP_D   = 8'h24;

  // ==========================================================================
  // Status register fields
  localparam int BIT_CAP_FLAG_A  = 7;
  localparam int BIT_CAP_FLAG_B  = 6;
  localparam int BIT_CAP_FLAG_C  = 5;
  localparam int BIT_CAP_FLAG_D  = 4;
  localparam int BIT_CMP_FLAG_A  = 3;
  localparam int BIT_CMP_FLAG_B  = 2;
  localparam int BIT_WRAP_FLAG   = 1;
  localparam int BIT_CLR_MATCH_A = 0;

  // ==========================================================================
  // Control register fields
  localparam int BIT_EDGE_SEL_A = 7;
  localparam int BIT_EDGE_SEL_B = 6;
  localparam int BIT_EDGE_SEL_C = 5;
  localparam int BIT_EDGE_SEL_D = 4;
  localparam int BIT_BUFFER_EN_A = 3;
  localparam int BIT_BUFFER_EN_B = 2;
  localparam int BIT_CLK_SEL_HI = 1;
  localparam int BIT_CLK_SEL_LO = 0;

  // ==========================================================================
  // Clock select codes and prescaler terminal counts
  localparam logic [1:0] CLK_DIV2  = 2'h0;
  localparam logic [1:0] CLK_DIV8  = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_EXT   = 2'h3;
  localparam logic [4:0] DIV2_LAST  = 5'h01;
  localparam logic [4:0] DIV8_LAST  = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  IRQ_EN_RST  = 8'h01;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] CMP_RST     = 16'hffff;
  localparam logic [15:0] CAP_RST     = 16'h0000;

endpackage

// File: rtl/tcc_pin_sync.sv
// Two-stage synchroniser with edge detection for a group of pins.
// Assumes the pins are asynchronous to MCLK; edges are one-cycle pulses.
`timescale 1ns/1ps
module tcc_pin_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Pins and detected edges
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;
  logic [1:0]   fill_q;

  // ==========================================================================
  // Synchroniser; only sync_q reads meta_q
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges are held off until the pipe holds real pin levels, so a pin
  // that is high out of reset does not fake a rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      fill_q <= 2'h0;
    end else if (fill_q != 2'h3) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  always_comb begin
    rise = (fill_q == 2'h3) ? (sync_q & ~prev_q) : '0;
    fall = (fill_q == 2'h3) ? (~sync_q & prev_q) : '0;
  end

endmodule

// File: verification/tcc_pin_source.sv
// Model of the sources on the capture pins and the external count clock.
// Assumes one bench process calls its tasks, all clocked by clk.
`timescale 1ns/1ps
module tcc_pin_source (
  // Clock
  input  wire logic       clk,
  // Pins toward the timer
  output logic      [3:0] cap_pin,
  output logic            ext_clk
);
  initial begin
    cap_pin = 4'hf;
    ext_clk = 1'b0;
  end

  // ====================
  // Drivers
  // Each level is held 8 cycles, well past the synchroniser delay
  task automatic set_pin(input int ch, input logic v);
    @(posedge clk);
    cap_pin[ch] <= v;
    repeat (8) @(posedge clk);
  endtask

  // The count clock stands low between ticks, never free-running
  task automatic ext_tick();
    @(posedge clk);
    ext_clk <= 1'b1;
    repeat (4) @(posedge clk);
    ext_clk <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// File: verification/test_timer_capture_compare_status_control.sv
// Self-checking bench for the timer status and control registers.
// Assumes the timer, its package and the pin source model are compiled.
`timescale 1ns/1ps
module test_timer_capture_compare_status_control;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic        low_power = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         irq;
  wire  [3:0]  pin;
  wire         ext;
  logic [31:0] rd;
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  always #5 mclk = ~mclk;

  tcc_timer dut (
    .MCLK(mclk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .CAP_PIN_A(pin[0]), .CAP_PIN_B(pin[1]), .CAP_PIN_C(pin[2]), .CAP_PIN_D(pin[3]),
    .EXT_CLK_PIN(ext), .LOW_POWER(low_power), .IRQ(irq)
  );

  tcc_pin_source src (.clk(mclk), .cap_pin(pin), .ext_clk(ext));

  // ====================
  // Reporting
  task automatic complete_run();
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // A hang must not run on forever
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ====================
  // Bus master
  // Address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // A low-power spell returns every register to its reset value
  task automatic lp_clear();
    @(posedge mclk);
    low_power <= 1'b1;
    repeat (2) @(posedge mclk);
    low_power <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  // ====================
  // Scenarios
  task automatic t_reset();
    rd_chk(tcc_pkg::OFS_STATUS, 32'h00, "status");
    rd_chk(tcc_pkg::OFS_CONTROL, 32'h00, "control");
    rd_chk(tcc_pkg::OFS_IRQ_EN, 32'h01, "irq enable");
    rd_chk(8'h3c, 32'h0, "unmapped");
    wr(tcc_pkg::OFS_STATUS, 32'hff);
    rd_chk(tcc_pkg::OFS_STATUS, 32'h01, "status ones");
    wr(tcc_pkg::OFS_CONTROL, 32'ha5);
    rd_chk(tcc_pkg::OFS_CONTROL, 32'ha5, "control rw");
    lp_clear();
    rd_chk(tcc_pkg::OFS_STATUS, 32'h00, "status low power");
    rd_chk(tcc_pkg::OFS_CONTROL, 32'h00, "control low power");
  endtask

  // External clock held still, so the counter is frozen at a known value
  task automatic t_capture();
    logic        lv;
    logic [7:0]  a;
    logic [31:0] v;
    for (int ch = 0; ch < 4; ch++) begin
      for (int e = 1; e >= 0; e--) begin
        lv = 1'(e);
        a = 8'(tcc_pkg::OFS_CAP_A + 8'(4 * ch));
        v = 32'h1000 + 32'(ch * 16 + e);
        lp_clear();
        wr(tcc_pkg::OFS_CONTROL, 32'h03 | (32'(e) << (7 - ch)));
        wr(tcc_pkg::OFS_COUNT, v);
        src.set_pin(ch, ~lv);
        rd_chk(a, 32'h0, "capture other edge");
        src.set_pin(ch, lv);
        rd_chk(a, v, "capture value");
        rd_chk(tcc_pkg::OFS_STATUS, 32'h80 >> ch, "capture flag");
      end
    end
  endtask

  task automatic t_buffer_a();
    lp_clear();
    wr(tcc_pkg::OFS_CONTROL, 32'h0b);
    wr(tcc_pkg::OFS_IRQ_EN, 32'h20);
    wr(tcc_pkg::OFS_COUNT, 32'h1111);
    src.set_pin(0, 1'b1);
    src.set_pin(0, 1'b0);
    wr(tcc_pkg::OFS_COUNT, 32'h2222);
    src.set_pin(0, 1'b1);
    rd_chk(tcc_pkg::OFS_CAP_A, 32'h1111, "single edge");
    wr(tcc_pkg::OFS_CONTROL, 32'h2b);
    src.set_pin(0, 1'b0);
    rd_chk(tcc_pkg::OFS_CAP_A, 32'h2222, "buffered a");
    rd_chk(tcc_pkg::OFS_CAP_C, 32'h1111, "buffer c");
    rd_chk(tcc_pkg::OFS_STATUS, 32'h80, "flag a only");
    src.set_pin(2, 1'b0);
    src.set_pin(2, 1'b1);
    rd_chk(tcc_pkg::OFS_CAP_C, 32'h1111, "c not loaded");
    // Flag a was read at one, flag c was not yet
    wr(tcc_pkg::OFS_STATUS, 32'h00);
    rd_chk(tcc_pkg::OFS_STATUS, 32'h20, "unread flag kept");
    chk("irq", 32'h1, {31'h0, irq});
    wr(tcc_pkg::OFS_STATUS, 32'hdf);
    rd_chk(tcc_pkg::OFS_STATUS, 32'h01, "read flag cleared");
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_buffer_b();
    lp_clear();
    wr(tcc_pkg::OFS_CONTROL, 32'h07);
    wr(tcc_pkg::OFS_COUNT, 32'h3333);
    src.set_pin(1, 1'b1);
    src.set_pin(1, 1'b0);
    wr(tcc_pkg::OFS_COUNT, 32'h4444);
    src.set_pin(1, 1'b1);
    src.set_pin(1, 1'b0);
    rd_chk(tcc_pkg::OFS_CAP_B, 32'h4444, "buffered b");
    rd_chk(tcc_pkg::OFS_CAP_D, 32'h3333, "buffer d");
    src.set_pin(3, 1'b1);
    src.set_pin(3, 1'b0);
    rd_chk(tcc_pkg::OFS_CAP_D, 32'h3333, "d not loaded");
    rd_chk(tcc_pkg::OFS_STATUS, 32'h50, "flags b d");
  endtask

  // A capture that lands in the cycle of a clearing write keeps its flag
  task automatic t_set_wins();
    lp_clear();
    wr(tcc_pkg::OFS_CONTROL, 32'h03);
    src.set_pin(0, 1'b1);
    src.set_pin(0, 1'b0);
    rd_chk(tcc_pkg::OFS_STATUS, 32'h80, "flag a armed");
    src.set_pin(0, 1'b1);
    // Both branches wait for the same edge, so the write data phase meets
    // the synchronised falling edge two edges after the pin moves
    fork
      src.set_pin(0, 1'b0);
      begin
        @(posedge mclk);
        wr(tcc_pkg::OFS_STATUS, 32'h00);
      end
    join
    rd_chk(tcc_pkg::OFS_STATUS, 32'h80, "set beats clear");
  endtask

  task automatic tick_case(input logic [15:0] ca, input logic [15:0] cb, input logic clr,
                           input logic [15:0] cnt, input logic [7:0] st,
                           input logic [15:0] nxt);
    lp_clear();
    wr(tcc_pkg::OFS_CONTROL, 32'h03);
    wr(tcc_pkg::OFS_CMP_A, {16'h0, ca});
    wr(tcc_pkg::OFS_CMP_B, {16'h0, cb});
    wr(tcc_pkg::OFS_STATUS, {31'h0, clr});
    wr(tcc_pkg::OFS_COUNT, {16'h0, cnt});
    src.ext_tick();
    rd_chk(tcc_pkg::OFS_STATUS, {24'h0, st}, "match flags");
    rd_chk(tcc_pkg::OFS_COUNT, {16'h0, nxt}, "count after tick");
  endtask

  task automatic t_compare();
    tick_case(16'hffff, 16'hffff, 1'b0, 16'hffff, 8'h0e, 16'h0000);
    tick_case(16'h0040, 16'hffff, 1'b1, 16'h0040, 8'h09, 16'h0000);
    tick_case(16'h0040, 16'h0080, 1'b0, 16'h0080, 8'h04, 16'h0081);
    tick_case(16'h0040, 16'hffff, 1'b0, 16'h0040, 8'h08, 16'h0041);
  endtask

  // Bus latency and prescaler phase blur the count, so a window is allowed
  task automatic t_prescale();
    logic [31:0] lo;
    for (int k = 0; k < 3; k++) begin
      lo = 32'(320 >> (2 * k + 1));
      lp_clear();
      wr(tcc_pkg::OFS_CONTROL, 32'(k));
      wr(tcc_pkg::OFS_COUNT, 32'h0);
      repeat (320) @(posedge mclk);
      xfer(1'b0, tcc_pkg::OFS_COUNT, 32'h0);
      checked++;
      if (rd < lo || rd > lo + 32'h3) begin
        n_errors++;
        $display("CHECK FAILED prescaled count expected %h seen %h", lo, rd);
      end
    end
  endtask

  // ====================
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_capture();
    t_buffer_a();
    t_buffer_b();
    t_set_wins();
    t_compare();
    t_prescale();
    complete_run();
  end
endmodule
